// ===== hw/rsq_pkg.sv
package rsq_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RELEASE_DLY_CYC = 16;
  localparam int unsigned POR_CYC = 8;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] RELEASE_CNT =
    CNT_W'(RELEASE_DLY_CYC);
  localparam logic [CNT_W-1:0] POR_CNT = CNT_W'(POR_CYC);
  // ---------------------------------------------------------------
  // pull-up disable field positions and reset value
  // ---------------------------------------------------------------
  localparam int unsigned PUD_RESET_BIT = 0;
  localparam int unsigned PUD_REQ_BIT = 1;
  localparam logic [1:0] PUD_RST_VAL = 2'h0;
  localparam int unsigned SYNC_STAGES = 3;
  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RSQ_POR,
    RSQ_HELD,
    RSQ_DELAY,
    RSQ_RUN
  } rsq_state_t;
endpackage : rsq_pkg

// ===== hw/rsq_req_in.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// one external request input: sync, sense, async path
// ---------------------------------------------------------------
module rsq_req_in
  import rsq_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic req_n_in,
  input wire logic edge_mode_in,
  input wire logic low_power_in,
  output logic req_out
);
  logic [SYNC_STAGES-1:0] sync_r;
  logic req_s;
  logic req_prev_r;
  logic edge_hit_r;

  // stage 0 feeds stage 1 only; stages 1 and 2 must agree
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sync_r <= '1;
    end else begin
      sync_r <= {sync_r[SYNC_STAGES-2:0], req_n_in};
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      req_prev_r <= 1'b1;
    end else if (sync_r[1] == sync_r[2]) begin
      req_prev_r <= sync_r[2];
    end
  end
  assign req_s = (sync_r[1] == sync_r[2]) ? sync_r[2] : req_prev_r;

  // falling-edge capture, held until the level returns high
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      edge_hit_r <= 1'b0;
    end else if (req_prev_r && !req_s) begin
      edge_hit_r <= 1'b1;
    end else if (req_s) begin
      edge_hit_r <= 1'b0;
    end
  end

  // low-power path is raw so a stopped clock can still wake us
  always_comb begin
    if (low_power_in) begin
      req_out = !req_n_in;
    end else if (edge_mode_in) begin
      req_out = edge_hit_r;
    end else begin
      req_out = !req_s;
    end
  end

  a_edge_sets: assert property (
    @(posedge clk_in) disable iff (srst_in)
    req_prev_r && !req_s |=> edge_hit_r)
    else $error("edge not captured");
endmodule : rsq_req_in

// ===== hw/rsq_top.sv
`timescale 1ns/1ns
// Function
// - low reset input holds device in reset
// - boot strap captured on reset release
// - internal reset drops after fixed clock count
// - power-on reset acts like external reset
// - reset output mirrors internal reset state
// - test logic reset only by test reset or power-on
// - pull-up disable bit switches reset pull-up off
// - requests pass raw in stop and wait
// - requests synchronized in other modes
// - each request level or falling-edge sensed
// - pull-up disable bit switches request pull-ups off
module rsq_top
  import rsq_pkg::*;
#(
  parameter int unsigned RELEASE_DLY = RELEASE_DLY_CYC
)(
  input wire logic CLK_SYS_IN,
  input wire logic SRST_IN,
  input wire logic RESET_N_IN,
  input wire logic TEST_RESET_N_IN,
  input wire logic BOOT_SOURCE_STRAP_IN,
  input wire logic EXT_REQUEST_A_N_IN,
  input wire logic EXT_REQUEST_B_N_IN,
  input wire logic EDGE_MODE_A_IN,
  input wire logic EDGE_MODE_B_IN,
  input wire logic LOW_POWER_IN,
  input wire logic [1:0] PULLUP_DISABLE_IN,
  input wire logic PULLUP_DISABLE_WE_IN,
  output logic RESET_STATE_OUT,
  output logic CHIP_RESET_OUT,
  output logic TEST_RESET_OUT,
  output logic BOOT_EXTERNAL_OUT,
  output logic RESET_PULLUP_EN_OUT,
  output logic REQ_PULLUP_EN_OUT,
  output logic EXT_REQUEST_A_OUT,
  output logic EXT_REQUEST_B_OUT
);
  rsq_state_t state_r;
  logic [SYNC_STAGES-1:0] rst_sync_r;
  logic [SYNC_STAGES-1:0] trst_sync_r;
  logic [SYNC_STAGES-1:0] boot_sync_r;
  logic rst_low_r;
  logic trst_low_r;
  logic boot_lvl_r;
  logic [CNT_W-1:0] cnt_r;
  logic boot_r;
  logic [1:0] pud_r;
  logic int_rst;
  logic [CNT_W-1:0] rel_cnt;

  assign rel_cnt = CNT_W'(RELEASE_DLY);

  // ---------------------------------------------------------------
  // pin synchronizers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      rst_sync_r <= '0;
      trst_sync_r <= '0;
      boot_sync_r <= '0;
    end else begin
      rst_sync_r <= {rst_sync_r[SYNC_STAGES-2:0], RESET_N_IN};
      trst_sync_r <= {trst_sync_r[SYNC_STAGES-2:0], TEST_RESET_N_IN};
      boot_sync_r <= {boot_sync_r[SYNC_STAGES-2:0], BOOT_SOURCE_STRAP_IN};
    end
  end

  // a change counts once stages 1 and 2 agree
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      rst_low_r <= 1'b1;
      trst_low_r <= 1'b1;
      boot_lvl_r <= 1'b0;
    end else begin
      if (rst_sync_r[1] == rst_sync_r[2]) begin
        rst_low_r <= !rst_sync_r[2];
      end
      if (trst_sync_r[1] == trst_sync_r[2]) begin
        trst_low_r <= !trst_sync_r[2];
      end
      if (boot_sync_r[1] == boot_sync_r[2]) begin
        boot_lvl_r <= boot_sync_r[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------
  // SRST_IN stands for the power-on event
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      state_r <= RSQ_POR;
      cnt_r <= POR_CNT;
    end else begin
      case (state_r)
        RSQ_POR: begin
          if (cnt_r != CNT_ZERO) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            state_r <= RSQ_HELD;
          end
        end
        RSQ_HELD: begin
          if (!rst_low_r) begin
            state_r <= RSQ_DELAY;
            cnt_r <= rel_cnt;
          end
        end
        RSQ_DELAY: begin
          if (rst_low_r) begin
            state_r <= RSQ_HELD;
          end else if (cnt_r <= 8'h01) begin
            state_r <= RSQ_RUN;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        RSQ_RUN: begin
          if (rst_low_r) begin
            state_r <= RSQ_HELD;
          end
        end
        default: begin
          state_r <= RSQ_POR;
        end
      endcase
    end
  end

  assign int_rst = (state_r != RSQ_RUN);

  // mode latched at the release edge of the pin
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      boot_r <= 1'b0;
    end else if (state_r == RSQ_HELD && !rst_low_r) begin
      boot_r <= boot_lvl_r;
    end
  end

  // pull-up disable bits are cleared only by power-on
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      pud_r <= PUD_RST_VAL;
    end else if (PULLUP_DISABLE_WE_IN && !int_rst) begin
      pud_r <= PULLUP_DISABLE_IN;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      RESET_STATE_OUT <= 1'b1;
      CHIP_RESET_OUT <= 1'b1;
      TEST_RESET_OUT <= 1'b1;
    end else begin
      RESET_STATE_OUT <= int_rst;
      CHIP_RESET_OUT <= int_rst;
      TEST_RESET_OUT <= trst_low_r;
    end
  end

  assign BOOT_EXTERNAL_OUT = boot_r;
  assign RESET_PULLUP_EN_OUT = !pud_r[PUD_RESET_BIT];
  assign REQ_PULLUP_EN_OUT = !pud_r[PUD_REQ_BIT];

  // ---------------------------------------------------------------
  // request inputs
  // ---------------------------------------------------------------
  rsq_req_in u_req_a (
    .clk_in(CLK_SYS_IN),
    .srst_in(SRST_IN),
    .req_n_in(EXT_REQUEST_A_N_IN),
    .edge_mode_in(EDGE_MODE_A_IN),
    .low_power_in(LOW_POWER_IN),
    .req_out(EXT_REQUEST_A_OUT)
  );

  rsq_req_in u_req_b (
    .clk_in(CLK_SYS_IN),
    .srst_in(SRST_IN),
    .req_n_in(EXT_REQUEST_B_N_IN),
    .edge_mode_in(EDGE_MODE_B_IN),
    .low_power_in(LOW_POWER_IN),
    .req_out(EXT_REQUEST_B_OUT)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_held_in_reset: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    rst_low_r |=> ##1 CHIP_RESET_OUT)
    else $error("chip reset dropped while pin low");
  a_boot_latched: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    state_r == RSQ_HELD && !rst_low_r |=> boot_r == $past(boot_lvl_r))
    else $error("boot mode not latched");
  // release exactly one full delay count after leaving the held state
  a_release_delay: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    $rose(state_r == RSQ_RUN) |->
      $past(state_r) == RSQ_DELAY &&
      $past(state_r, RELEASE_DLY) == RSQ_DELAY &&
      $past(state_r, RELEASE_DLY + 1) == RSQ_HELD)
    else $error("reset released without delay");
  a_por_holds: assert property (
    @(posedge CLK_SYS_IN)
    $fell(SRST_IN) |-> CHIP_RESET_OUT [*8])
    else $error("power-on reset too short");
  a_out_mirror: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    1'b1 |=> RESET_STATE_OUT == ($past(state_r) != RSQ_RUN) &&
      CHIP_RESET_OUT == RESET_STATE_OUT)
    else $error("reset output differs from internal");
  a_test_alone: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    !trst_low_r |=> !TEST_RESET_OUT)
    else $error("test logic reset without test reset");
  a_pullup_rst: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    PULLUP_DISABLE_WE_IN && !int_rst |=>
      RESET_PULLUP_EN_OUT == !$past(PULLUP_DISABLE_IN[PUD_RESET_BIT]))
    else $error("reset pull-up not following write");
  a_pud_refused: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    int_rst |=> $stable(pud_r))
    else $error("pull-up write taken during reset");
  a_lowpower_raw: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    LOW_POWER_IN |-> EXT_REQUEST_A_OUT == !EXT_REQUEST_A_N_IN)
    else $error("low-power request not raw");
  a_pullup_req: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    PULLUP_DISABLE_WE_IN && !int_rst |=>
      REQ_PULLUP_EN_OUT == !$past(PULLUP_DISABLE_IN[PUD_REQ_BIT]))
    else $error("request pull-up not following write");

  c_release: cover property (@(posedge CLK_SYS_IN) $fell(CHIP_RESET_OUT));
  c_boot_ext: cover property (@(posedge CLK_SYS_IN) $rose(boot_r));
  c_req_edge: cover property (@(posedge CLK_SYS_IN)
    EDGE_MODE_A_IN && $rose(EXT_REQUEST_A_OUT));
endmodule : rsq_top

// ===== sim/rsq_board.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// board side: open-drain pin drivers and a tied strap
// ---------------------------------------------------------------
module rsq_board (
  input wire logic clk_in,
  input wire logic [3:0] pull_low_in,
  input wire logic strap_hi_in,
  input wire logic rst_pu_en_in,
  input wire logic req_pu_en_in,
  output logic [3:0] pin_out,
  output logic strap_out
);
  // pin order: reset, test reset, request a, request b
  logic [3:0] pu;
  assign pu = {req_pu_en_in, req_pu_en_in, 1'b1, rst_pu_en_in};
  // strap is tied solid by the board, never left floating
  assign strap_out = strap_hi_in;
  // released pin without pull-up drifts, so nothing reads it as stable
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 4; i++) begin
      pin_out[i] <= pull_low_in[i] ? 1'b0 : (pu[i] ? 1'b1 : ~pin_out[i]);
    end
  end
endmodule : rsq_board

// ===== sim/rsq_top_tb.sv
`timescale 1ns/1ns
module rsq_top_tb;
  import rsq_pkg::*;
  localparam int DLY = 4;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic strap = 1'b1;
  logic lp = 1'b0;
  logic we = 1'b0;
  logic [1:0] em = 2'h0;
  logic [1:0] pud = 2'h0;
  logic [3:0] pull = 4'h0;
  logic [3:0] pin;
  logic strap_pin, rso, cro, tro, boot, rpe, qpe, qa, qb;
  int fail_count = 0;
  int num_checks = 0;
  int n;
  initial forever #5 clk = ~clk;
  rsq_board board (.clk_in(clk), .pull_low_in(pull), .strap_hi_in(strap),
    .rst_pu_en_in(rpe), .req_pu_en_in(qpe), .pin_out(pin),
    .strap_out(strap_pin));
  rsq_top #(.RELEASE_DLY(DLY)) uut (.CLK_SYS_IN(clk), .SRST_IN(srst),
    .RESET_N_IN(pin[0]), .TEST_RESET_N_IN(pin[1]),
    .BOOT_SOURCE_STRAP_IN(strap_pin), .EXT_REQUEST_A_N_IN(pin[2]),
    .EXT_REQUEST_B_N_IN(pin[3]), .EDGE_MODE_A_IN(em[0]),
    .EDGE_MODE_B_IN(em[1]), .LOW_POWER_IN(lp), .PULLUP_DISABLE_IN(pud),
    .PULLUP_DISABLE_WE_IN(we), .RESET_STATE_OUT(rso),
    .CHIP_RESET_OUT(cro), .TEST_RESET_OUT(tro), .BOOT_EXTERNAL_OUT(boot),
    .RESET_PULLUP_EN_OUT(rpe), .REQ_PULLUP_EN_OUT(qpe),
    .EXT_REQUEST_A_OUT(qa), .EXT_REQUEST_B_OUT(qb));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task chk(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task fall_count();
    n = 0;
    while (cro !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
  endtask : fall_count
  task wr_pud(input logic [1:0] v);
    pud = v;
    we = 1'b1;
    tick(1);
    we = 1'b0;
    tick(2);
  endtask : wr_pud
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_por();
    chk("por chip reset", 1'b1, cro);
    chk("por pull-ups", 1'b1, rpe & qpe);
    fall_count();
    chk("por length", 1'b1, n > DLY && n < DLY + 20);
    chk("boot ext", 1'b1, boot);
    $display("done por");
  endtask : t_por
  task t_pin_reset();
    strap = 1'b0;
    pull = 4'h1;
    tick(8);
    chk("held", 1'b1, cro);
    chk("state out", 1'b1, rso);
    chk("test kept", 1'b0, tro);
    tick(30);
    chk("still held", 1'b1, cro & rso);
    pull = 4'h0;
    fall_count();
    chk("release dly", 1'b1, n > DLY && n < DLY + 9);
    chk("state mirror", 1'b0, rso);
    chk("boot int", 1'b0, boot);
    $display("done pin reset");
  endtask : t_pin_reset
  task t_full();
    pull = 4'h3;
    tick(8);
    chk("test reset", 1'b1, tro);
    chk("full chip", 1'b1, cro);
    pull = 4'h0;
    fall_count();
    chk("test free", 1'b0, tro);
    $display("done full reset");
  endtask : t_full
  task t_req();
    for (int m = 0; m < 4; m++) begin
      em = {m[1], m[1]};
      pull[2 + m[0]] = 1'b1;
      tick(1);
      chk("req not raw", 1'b0, m[0] ? qb : qa);
      tick(5);
      chk("req seen", 1'b1, m[0] ? qb : qa);
      pull = 4'h0;
      tick(6);
      chk("req gone", 1'b0, m[0] ? qb : qa);
    end
    em = 2'h0;
    lp = 1'b1;
    pull = 4'hc;
    tick(1);
    chk("raw a", 1'b1, qa);
    chk("raw b", 1'b1, qb);
    pull = 4'h0;
    tick(1);
    lp = 1'b0;
    tick(6);
    $display("done requests");
  endtask : t_req
  task t_pud();
    pull = 4'h1;
    tick(8);
    wr_pud(2'h3);
    chk("pud refused", 1'b1, rpe & qpe);
    pull = 4'h0;
    fall_count();
    wr_pud(2'h1);
    chk("rst pu off", 1'b0, rpe);
    chk("req pu on", 1'b1, qpe);
    wr_pud(2'h2);
    chk("req pu off", 1'b0, qpe);
    chk("rst pu on", 1'b1, rpe);
    $display("done pull-ups");
  endtask : t_pud
  task summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
  initial begin
    tick(8);
    srst = 1'b0;
    tick(1);
    t_por();
    t_pin_reset();
    t_full();
    t_req();
    t_pud();
    summarize();
  end
endmodule : rsq_top_tb
